// [voltage_reference_control.sv]
`timescale 1ns/1ps

// What this block does
// R1: Software enable bit powers the reference.
// R2: Reference routes to converter and both comparator inputs.
// R3: Each buffer offers gains 1x, 2x, 4x.
// R4: Converter gain field enables and sets buffer.
// R5: Comparator gain field enables and sets buffer.
// R6: Software should clear gains when reference off.
// R7: Ready stays low until circuits settle.
// R8: Internal oscillator source 010, frequency 000x outside sleep needs reference.
// R9: Brown-out always-on or fast-start modes need reference.
// R10: High-voltage regulator mode outside sleep needs reference.
// R11: Gain field 00 off, 01/10/11 gains.
// R12: Ready reads zero when off or settling.
// R13: High-voltage variant ready always reads one.
// R14: Power request ORs enable with all requirements.
// R15: Settling counter starts on request, clears off.
module voltage_reference_control (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic                       clk_en,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic                            pready,
	output logic [31:0]                     prdata,
	output logic                            pslverr,
	// System conditions
	input  wire reference_pkg::system_cfg_t sys_cfg,
	// Analog side
	output logic                            power_on,
	output reference_pkg::buffer_ctl_t      adc_buf,
	output reference_pkg::buffer_ctl_t      cmp_buf,
	output logic                            route_adc,
	output logic                            route_cmp_pos,
	output logic                            route_cmp_neg,
	// Interrupt
	output logic                            irq
);

	// =====================================================================
	// State
	reference_pkg::state_t s_reg;
	reference_pkg::state_t s_next;

	logic access;
	logic wr;
	logic rd_hit;
	logic needs_osc;
	logic needs_bor;
	logic needs_ldo;
	logic request;
	logic high_voltage;
	logic ready_val;
	logic [7:0] ctrl_read;

	assign access = psel && penable && !s_reg.pready;
	assign wr     = access && pwrite && pstrb[0];

	// =====================================================================
	// Peripheral requirements
	always_comb begin
		high_voltage = s_reg.config_bits[reference_pkg::CFG_HV_BIT];
		needs_osc = (sys_cfg.oscillator_source_select == 3'h2) &&
			(sys_cfg.internal_osc_freq_select[3:1] == 3'h0) &&
			!sys_cfg.sleeping; // R8
		needs_bor = (sys_cfg.brownout_enable_mode == 2'h3) ||
			(((sys_cfg.brownout_enable_mode == 2'h2) ||
			(sys_cfg.brownout_enable_mode == 2'h1)) &&
			sys_cfg.brownout_fast_start); // R9
		needs_ldo = high_voltage &&
			s_reg.config_bits[reference_pkg::CFG_REG_PM_BIT] &&
			!sys_cfg.sleeping; // R10
		request = s_reg.reference_enable || needs_osc || needs_bor || needs_ldo; // R1 R14
		ready_val = high_voltage ? 1'b1 : s_reg.ready; // R12 R13
		ctrl_read = {s_reg.reference_enable, ready_val, 2'h0,
			s_reg.comparator_buffer_gain, s_reg.converter_buffer_gain};
	end

	// =====================================================================
	// Next state
	always_comb begin
		s_next = s_reg;
		rd_hit = 1'b1;
		s_next.pready  = access;
		s_next.pslverr = 1'b0;
		s_next.prdata  = 32'h0000_0000;

		// Register bus.
		case (paddr)
			reference_pkg::CONTROL_OFFSET: begin
				s_next.prdata = {24'h00_0000, ctrl_read};
				if (wr) begin
					s_next.reference_enable = pwdata[reference_pkg::ENABLE_BIT]; // R1
					s_next.comparator_buffer_gain = reference_pkg::gain_t'(
						pwdata[reference_pkg::CMP_GAIN_LSB +: 2]); // R5
					s_next.converter_buffer_gain = reference_pkg::gain_t'(
						pwdata[reference_pkg::ADC_GAIN_LSB +: 2]); // R4
				end
			end
			reference_pkg::STATUS_OFFSET: begin
				s_next.prdata = {30'h0000_0000, s_reg.status};
				if (wr) begin
					s_next.status = s_reg.status & ~pwdata[1:0];
				end
			end
			reference_pkg::MASK_OFFSET: begin
				s_next.prdata = {30'h0000_0000, s_reg.mask};
				if (wr) begin
					s_next.mask = pwdata[1:0];
				end
			end
			reference_pkg::CONFIG_OFFSET: begin
				s_next.prdata = {30'h0000_0000, s_reg.config_bits};
				if (wr) begin
					s_next.config_bits = pwdata[1:0];
				end
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
		if (!access) begin
			s_next.prdata = 32'h0000_0000;
		end
		s_next.pslverr = access && !rd_hit;

		// Settling sequence.
		s_next.power_on = request; // R14
		case (s_reg.state)
			reference_pkg::ST_OFF: begin
				s_next.ready = 1'b0;
				s_next.count = 10'h000;
				if (request) begin
					s_next.state = reference_pkg::ST_SETTLING; // R15
				end
			end
			reference_pkg::ST_SETTLING: begin
				s_next.ready = 1'b0; // R7
				s_next.count = s_reg.count + 10'h001;
				if (!request) begin
					s_next.state = reference_pkg::ST_OFF; // R15
				end else if (s_reg.count == reference_pkg::SETTLE_COUNT - 10'h001) begin
					s_next.state = reference_pkg::ST_READY;
					s_next.ready = 1'b1; // R7
				end
			end
			reference_pkg::ST_READY: begin
				if (!request) begin
					s_next.state = reference_pkg::ST_OFF;
					s_next.ready = 1'b0; // R12
				end
			end
			default: begin
				s_next.state = reference_pkg::ST_OFF;
				s_next.ready = 1'b0;
			end
		endcase

		// Buffer controls from the gain fields.
		s_next.adc_buf.en   = (s_next.converter_buffer_gain != reference_pkg::GAIN_OFF); // R11
		s_next.adc_buf.mult = s_next.converter_buffer_gain; // R3
		s_next.cmp_buf.en   = (s_next.comparator_buffer_gain != reference_pkg::GAIN_OFF); // R11
		s_next.cmp_buf.mult = s_next.comparator_buffer_gain; // R3

		// Events: a set in the same cycle as a clear wins.
		if (s_next.ready && !s_reg.ready) begin
			s_next.status[reference_pkg::EVT_READY_RISE] = 1'b1;
		end
		if (!s_next.ready && s_reg.ready) begin
			s_next.status[reference_pkg::EVT_READY_FALL] = 1'b1;
		end
		s_next.irq = |(s_next.status & s_next.mask);
	end

	// =====================================================================
	// Registers
	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '0;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	// =====================================================================
	// Outputs
	assign pready        = s_reg.pready;
	assign prdata        = s_reg.prdata;
	assign pslverr       = s_reg.pslverr;
	assign power_on      = s_reg.power_on;
	assign adc_buf       = s_reg.adc_buf;
	assign cmp_buf       = s_reg.cmp_buf;
	assign route_adc     = s_reg.adc_buf.en; // R2
	assign route_cmp_pos = s_reg.cmp_buf.en; // R2
	assign route_cmp_neg = s_reg.cmp_buf.en; // R2
	assign irq           = s_reg.irq;

endmodule : voltage_reference_control

// [reference_pkg.sv]
package reference_pkg;

	// =====================================================================
	// Register map
	localparam logic [7:0]  CONTROL_OFFSET     = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET      = 8'h04;
	localparam logic [7:0]  MASK_OFFSET        = 8'h08;
	localparam logic [7:0]  CONFIG_OFFSET      = 8'h0C;

	// =====================================================================
	// Control register fields
	localparam int          ENABLE_BIT         = 7;
	localparam int          READY_BIT          = 6;
	localparam int          CMP_GAIN_LSB       = 2;
	localparam int          ADC_GAIN_LSB       = 0;

	// Status bits: ready rose, ready fell.
	localparam int          EVT_READY_RISE     = 0;
	localparam int          EVT_READY_FALL     = 1;

	// Config register fields.
	localparam int          CFG_REG_PM_BIT     = 0;
	localparam int          CFG_HV_BIT         = 1;

	// =====================================================================
	// Reset values and timing
	localparam logic [7:0]  CONTROL_RESET      = 8'h00;
	localparam logic [1:0]  STATUS_RESET       = 2'h0;
	localparam logic [1:0]  MASK_RESET         = 2'h0;
	localparam logic [1:0]  CONFIG_RESET       = 2'h0;
	localparam int          CLK_HZ             = 40_000_000;
	localparam int          SETTLE_US          = 25;
	localparam int          SETTLE_CYCLES      = (SETTLE_US * (CLK_HZ / 1_000_000));
	localparam logic [9:0]  SETTLE_COUNT       = 10'(SETTLE_CYCLES);

	// =====================================================================
	// Types
	typedef enum logic [1:0] {
		GAIN_OFF = 2'h0,
		GAIN_1X  = 2'h1,
		GAIN_2X  = 2'h2,
		GAIN_4X  = 2'h3
	} gain_t;

	typedef enum logic [1:0] {
		ST_OFF      = 2'h0,
		ST_SETTLING = 2'h1,
		ST_READY    = 2'h2
	} settle_state_t;

	typedef struct packed {
		logic       en;
		logic [1:0] mult;
	} buffer_ctl_t;

	typedef struct packed {
		logic [2:0] oscillator_source_select;
		logic [3:0] internal_osc_freq_select;
		logic [1:0] brownout_enable_mode;
		logic       brownout_fast_start;
		logic       sleeping;
	} system_cfg_t;

	typedef struct packed {
		logic          reference_enable;
		gain_t         comparator_buffer_gain;
		gain_t         converter_buffer_gain;
		logic [1:0]    status;
		logic [1:0]    mask;
		logic [1:0]    config_bits;
		settle_state_t state;
		logic [9:0]    count;
		logic          ready;
		logic          power_on;
		buffer_ctl_t   adc_buf;
		buffer_ctl_t   cmp_buf;
		logic          irq;
		logic          pready;
		logic [31:0]   prdata;
		logic          pslverr;
	} state_t;

endpackage : reference_pkg

// [reference_properties.sv]
`timescale 1ns/1ps
module reference_properties (
	// Clock, reset and bus
	input wire logic                       clk,
	input wire logic                       reset,
	input wire logic                       clk_en,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic                       pready,
	input wire logic [31:0]                prdata,
	input wire logic                       pslverr,
	// System and analog side
	input wire reference_pkg::system_cfg_t sys_cfg,
	input wire logic                       power_on,
	input wire reference_pkg::buffer_ctl_t adc_buf,
	input wire reference_pkg::buffer_ctl_t cmp_buf,
	input wire logic                       route_adc,
	input wire logic                       route_cmp_pos,
	input wire logic                       route_cmp_neg
);
	logic osc_req;
	logic bor_req;
	assign osc_req = sys_cfg.oscillator_source_select == 3'h2 &&
		sys_cfg.internal_osc_freq_select[3:1] == 3'h0 && !sys_cfg.sleeping;
	assign bor_req = sys_cfg.brownout_enable_mode == 2'h3 || (sys_cfg.brownout_fast_start &&
		(sys_cfg.brownout_enable_mode == 2'h2 || sys_cfg.brownout_enable_mode == 2'h1));
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// A buffer setting only moves shortly after a register write or a reset.
	sequence recent_write_s;
		$past(reset) || $past(psel && pwrite) || $past(psel && pwrite, 2) || $past(psel && pwrite, 3);
	endsequence
	adc_decode_a: assert property (adc_buf.en == (adc_buf.mult != 2'h0))
		else $error("adc buffer decode wrong");
	cmp_decode_a: assert property (cmp_buf.en == (cmp_buf.mult != 2'h0))
		else $error("cmp buffer decode wrong");
	route_follow_a: assert property (route_adc == adc_buf.en && route_cmp_pos == cmp_buf.en &&
		route_cmp_neg == cmp_buf.en) else $error("routing wrong");
	osc_need_a: assert property (osc_req && clk_en |=> power_on)
		else $error("oscillator need ignored");
	bor_need_a: assert property (bor_req && clk_en |=> power_on)
		else $error("brown-out need ignored");
	power_drop_a: assert property ($fell(power_on) |-> $past(reset) || !$past(osc_req || bor_req))
		else $error("power dropped while needed");
	adc_hold_a: assert property ($changed(adc_buf) |-> recent_write_s)
		else $error("adc buffer moved alone");
	cmp_hold_a: assert property ($changed(cmp_buf) |-> recent_write_s)
		else $error("cmp buffer moved alone");
	// An access phase seen by a running block is answered at the next edge.
	sequence bus_access_s;
		psel && penable && !pready && clk_en;
	endsequence
	answer_next_a: assert property (bus_access_s |=> pready)
		else $error("bus access not answered");
	pulse_once_a: assert property (pready && clk_en |=> !pready)
		else $error("bus answer held too long");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("bus error without answer");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
endmodule : reference_properties

// [analog_core_model.sv]
`timescale 1ns/1ps
module analog_core_model (
	// Controls from the block
	input  wire logic                       power_on,
	input  wire reference_pkg::buffer_ctl_t adc_buf,
	input  wire reference_pkg::buffer_ctl_t cmp_buf,
	// Buffered levels in units of the bare reference
	output logic [2:0]                      adc_level,
	output logic [2:0]                      cmp_level
);
	assign adc_level = (power_on && adc_buf.en) ? 3'h1 << (adc_buf.mult - 2'h1) : 3'h0;
	assign cmp_level = (power_on && cmp_buf.en) ? 3'h1 << (cmp_buf.mult - 2'h1) : 3'h0;
endmodule : analog_core_model

// [tb_voltage_reference_control.sv]
`timescale 1ns/1ps
module tb_voltage_reference_control;
	logic clk, reset, clk_en, psel, penable, pwrite, pready, pslverr, power_on, irq, e;
	logic route_adc, route_cmp_pos, route_cmp_neg;
	logic [3:0] pstrb;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0] adc_level, cmp_level;
	reference_pkg::system_cfg_t sys_cfg;
	reference_pkg::buffer_ctl_t adc_buf, cmp_buf;
	int miscompares, checks_done;
	localparam logic [13:0] GAIN_ROWS [6] = '{{8'h85, 3'h1, 3'h1}, {8'h8A, 3'h2, 3'h2},
		{8'h8F, 3'h4, 3'h4}, {8'hBF, 3'h4, 3'h4}, {8'h03, 3'h0, 3'h0}, {8'h00, 3'h0, 3'h0}};
	localparam logic [11:0] CFG_ROWS [10] = '{12'h401, 12'h421, 12'h440, 12'h402, 12'h019,
		12'h01B, 12'h010, 12'h015, 12'h00D, 12'h008};
	voltage_reference_control dut_u (.clk, .reset, .clk_en, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .sys_cfg, .power_on,
		.adc_buf, .cmp_buf, .route_adc, .route_cmp_pos, .route_cmp_neg, .irq);
	analog_core_model model_u (.power_on, .adc_buf, .cmp_buf, .adc_level, .cmp_level);
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic check(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			$display("CHECK FAILED %0t seen %h exp %h", $time, s, x);
			miscompares++;
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#100us;
		miscompares++;
		print_verdict();
	end
	initial begin
		{reset, clk_en, psel, penable, pwrite, paddr, pwdata} = {5'h18, 40'h0};
		pstrb = 4'hF;
		sys_cfg = '0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		check(q, 32'h0);
		foreach (GAIN_ROWS[i]) begin
			apb(1'b1, 8'h00, {24'h0, GAIN_ROWS[i][13:6]});
			repeat (2) @(posedge clk);
			check({29'h0, adc_level}, {29'h0, GAIN_ROWS[i][5:3]});
			check({29'h0, cmp_level}, {29'h0, GAIN_ROWS[i][2:0]});
			check({29'h0, route_adc, route_cmp_pos, route_cmp_neg}, {29'h0, |GAIN_ROWS[i][7:6],
				|GAIN_ROWS[i][9:8], |GAIN_ROWS[i][9:8]});
			check({31'h0, power_on}, {31'h0, GAIN_ROWS[i][13]});
			apb(1'b0, 8'h00, 32'h0);
			check(q & ~32'h40, {24'h0, GAIN_ROWS[i][13:6] & 8'h8F});
		end
		$display("gain table done");
		foreach (CFG_ROWS[i]) begin
			sys_cfg <= CFG_ROWS[i][11:1];
			repeat (2) @(posedge clk);
			check({31'h0, power_on}, {31'h0, CFG_ROWS[i][0]});
		end
		$display("requirement table done");
		apb(1'b1, 8'h08, 32'h3);
		apb(1'b1, 8'h00, 32'h80);
		apb(1'b0, 8'h00, 32'h0);
		check(q, 32'h80);
		repeat (1000) @(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		check(q, 32'hC0);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		check(q, 32'h2);
		apb(1'b1, 8'h04, 32'h3);
		check({31'h0, irq}, 32'h0);
		$display("settling done");
		apb(1'b1, 8'h0C, 32'h3);
		apb(1'b0, 8'h00, 32'h0);
		check(q, 32'h40);
		check({31'h0, power_on}, 32'h1);
		sys_cfg <= 11'h1;
		repeat (2) @(posedge clk);
		check({31'h0, power_on}, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check({q[30:0], e}, 32'h1);
		$display("variant and unmapped done");
		apb(1'b1, 8'h00, 32'h8F);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check({31'h0, power_on}, 32'h0);
		check({29'h0, adc_level}, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		check(q, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		check(q, 32'h0);
		$display("mid-run reset done");
		clk_en <= 1'b0;
		sys_cfg <= 11'h200;
		repeat (3) @(posedge clk);
		check({31'h0, power_on}, 32'h0);
		clk_en <= 1'b1;
		repeat (2) @(posedge clk);
		check({31'h0, power_on}, 32'h1);
		pstrb <= 4'h0;
		apb(1'b1, 8'h00, 32'h8F);
		pstrb <= 4'hF;
		apb(1'b0, 8'h00, 32'h0);
		check(q, 32'h0);
		$display("freeze and strobe done");
		print_verdict();
	end
endmodule : tb_voltage_reference_control
bind voltage_reference_control reference_properties chk_u (.clk, .reset, .clk_en, .psel,
	.penable, .pwrite, .pready, .prdata, .pslverr, .sys_cfg, .power_on, .adc_buf, .cmp_buf,
	.route_adc, .route_cmp_pos, .route_cmp_neg);
